// *** rtl/timer_unit.sv ***
// Eight-bit timer with compare, capture, waveform and flag logic
`timescale 1ns/100ps
module timer_unit (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Asynchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic external_count_pin, // External count input
  input wire logic capture_input_pin, // Capture trigger input
  input wire logic [3:0] vector_ack, // Vector executed per flag
  output logic [3:0] irq_request, // Masked requests per flag
  output logic compare_output_a, // Waveform output A
  output logic compare_output_b // Waveform output B
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] control_reg_a;
  logic [7:0] control_reg_b;
  logic [7:0] counter_value;
  logic [7:0] compare_value_a;
  logic [7:0] compare_value_b;
  logic [7:0] active_cmp_a;
  logic [7:0] active_cmp_b;
  logic [7:0] capture_register;
  logic [7:0] interrupt_mask_reg;
  logic [7:0] timer1_flag_reg;
  logic count_down;
  logic [timer_pkg::PRESCALE_W-1:0] prescale;
  logic [timer_pkg::PRESCALE_W-1:0] prescale_prev;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic capt_sync1;
  logic capt_sync2;
  logic capt_prev;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  function automatic timer_pkg::family_t mode_family(input logic [3:0] m);
    unique case (m)
      timer_pkg::WGM_CTC_A, timer_pkg::WGM_CTC_CAPT:
        mode_family = timer_pkg::FAM_CTC;
      timer_pkg::WGM_FAST_MAX, timer_pkg::WGM_FAST_A,
      timer_pkg::WGM_FAST_CAPT:
        mode_family = timer_pkg::FAM_FAST;
      timer_pkg::WGM_PC_MAX, timer_pkg::WGM_PC_A:
        mode_family = timer_pkg::FAM_PHASE;
      default:
        mode_family = timer_pkg::FAM_NORMAL;
    endcase
  endfunction : mode_family

  function automatic timer_pkg::top_sel_t top_source(input logic [3:0] m);
    unique case (m)
      timer_pkg::WGM_CTC_A, timer_pkg::WGM_PC_A, timer_pkg::WGM_FAST_A:
        top_source = timer_pkg::TOP_CMP_A;
      timer_pkg::WGM_CTC_CAPT, timer_pkg::WGM_FAST_CAPT:
        top_source = timer_pkg::TOP_CAPT;
      default:
        top_source = timer_pkg::TOP_MAX;
    endcase
  endfunction : top_source

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [2:0] clock_source_select;
  logic [3:0] waveform_mode_select;
  logic [1:0] out_mode_a;
  logic [1:0] out_mode_b;
  timer_pkg::family_t family;
  timer_pkg::top_sel_t top_sel;
  logic [7:0] top_value;

  assign clock_source_select =
    control_reg_b[timer_pkg::CB_CS_LSB +: 3];
  assign waveform_mode_select = {control_reg_b[timer_pkg::CB_WGM_HI_LSB +: 2],
                                 control_reg_a[timer_pkg::CA_WGM_LO_LSB +: 2]};
  assign out_mode_a = control_reg_a[timer_pkg::CA_MODE_A_LSB +: 2];
  assign out_mode_b = control_reg_a[timer_pkg::CA_MODE_B_LSB +: 2];
  assign family = mode_family(waveform_mode_select);
  assign top_sel = top_source(waveform_mode_select);

  always_comb
  begin
    unique case (top_sel)
      timer_pkg::TOP_CMP_A: top_value = active_cmp_a;
      timer_pkg::TOP_CAPT: top_value = capture_register;
      default: top_value = timer_pkg::MAX_VAL;
    endcase
  end

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  logic bus_access;
  logic bus_write;
  logic addr_ok;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_capt;
  logic wr_mask;
  logic wr_flags;
  logic [7:0] wbyte;

  assign bus_access = psel && penable;
  assign bus_write = bus_access && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign addr_ok = addr_is(paddr, timer_pkg::OFS_CTRL_A)
                || addr_is(paddr, timer_pkg::OFS_CTRL_B)
                || addr_is(paddr, timer_pkg::OFS_COUNT)
                || addr_is(paddr, timer_pkg::OFS_CMP_A)
                || addr_is(paddr, timer_pkg::OFS_CMP_B)
                || addr_is(paddr, timer_pkg::OFS_CAPT)
                || addr_is(paddr, timer_pkg::OFS_MASK)
                || addr_is(paddr, timer_pkg::OFS_FLAGS);
  assign wr_ctrl_a = bus_write && addr_is(paddr, timer_pkg::OFS_CTRL_A);
  assign wr_ctrl_b = bus_write && addr_is(paddr, timer_pkg::OFS_CTRL_B);
  assign wr_count = bus_write && addr_is(paddr, timer_pkg::OFS_COUNT);
  assign wr_cmp_a = bus_write && addr_is(paddr, timer_pkg::OFS_CMP_A);
  assign wr_cmp_b = bus_write && addr_is(paddr, timer_pkg::OFS_CMP_B);
  assign wr_capt = bus_write && addr_is(paddr, timer_pkg::OFS_CAPT);
  assign wr_mask = bus_write && addr_is(paddr, timer_pkg::OFS_MASK);
  assign wr_flags = bus_write && addr_is(paddr, timer_pkg::OFS_FLAGS);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (1'b1)
        addr_is(paddr, timer_pkg::OFS_CTRL_A): prdata <= {24'h000000,
                                                          control_reg_a};
        addr_is(paddr, timer_pkg::OFS_CTRL_B): prdata <= {24'h000000,
                                                          control_reg_b};
        addr_is(paddr, timer_pkg::OFS_COUNT): prdata <= {24'h000000,
                                                         counter_value};
        addr_is(paddr, timer_pkg::OFS_CMP_A): prdata <= {24'h000000,
                                                         compare_value_a};
        addr_is(paddr, timer_pkg::OFS_CMP_B): prdata <= {24'h000000,
                                                         compare_value_b};
        addr_is(paddr, timer_pkg::OFS_CAPT): prdata <= {24'h000000,
                                                        capture_register};
        addr_is(paddr, timer_pkg::OFS_MASK): prdata <= {24'h000000,
                                                        interrupt_mask_reg};
        addr_is(paddr, timer_pkg::OFS_FLAGS): prdata <= {24'h000000,
                                                         timer1_flag_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg_a <= timer_pkg::REG_RESET;
      control_reg_b <= timer_pkg::REG_RESET;
      interrupt_mask_reg <= timer_pkg::REG_RESET;
    end
    else
    begin
      if (wr_ctrl_a)
        control_reg_a <= wbyte;
      // Force bits are strobes and are not stored
      if (wr_ctrl_b)
        control_reg_b <= wbyte & timer_pkg::CB_STORE_MASK;
      if (wr_mask)
        interrupt_mask_reg <= wbyte & timer_pkg::FLG_USED;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
      capt_sync1 <= 1'b0;
      capt_sync2 <= 1'b0;
      capt_prev <= 1'b0;
    end
    else
    begin
      ext_sync1 <= external_count_pin;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
      capt_sync1 <= capture_input_pin;
      capt_sync2 <= capt_sync1;
      capt_prev <= capt_sync2;
    end
  end

  logic capture_event;
  assign capture_event = control_reg_b[timer_pkg::CB_CAPT_EDGE]
                       ? (capt_sync2 && !capt_prev)
                       : (!capt_sync2 && capt_prev);

  // ----------------------------------------------------------------
  // Prescaler and clock select
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale <= '0;
      prescale_prev <= '0;
    end
    else
    begin
      prescale <= prescale + 1'b1;
      prescale_prev <= prescale;
    end
  end

  // Falling tap bit marks one full divider period
  logic [3:0] tap_pulse;
  genvar gi;
  localparam int TAPS [4] = '{timer_pkg::TAP_DIV8, timer_pkg::TAP_DIV64,
                              timer_pkg::TAP_DIV256, timer_pkg::TAP_DIV1024};
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_tap
      assign tap_pulse[gi] = prescale_prev[TAPS[gi]] && !prescale[TAPS[gi]];
    end
  endgenerate

  logic timer_tick;
  always_comb
  begin
    unique case (clock_source_select)
      timer_pkg::CS_NONE: timer_tick = 1'b0;
      timer_pkg::CS_DIRECT: timer_tick = 1'b1;
      timer_pkg::CS_DIV8: timer_tick = tap_pulse[0];
      timer_pkg::CS_DIV64: timer_tick = tap_pulse[1];
      timer_pkg::CS_DIV256: timer_tick = tap_pulse[2];
      timer_pkg::CS_DIV1024: timer_tick = tap_pulse[3];
      timer_pkg::CS_EXT_FALL: timer_tick = !ext_sync2 && ext_prev;
      timer_pkg::CS_EXT_RISE: timer_tick = ext_sync2 && !ext_prev;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter unit
  // ----------------------------------------------------------------
  logic at_top;
  logic at_bottom;
  logic [7:0] next_count;
  logic next_down;

  assign at_top = (counter_value == top_value);
  assign at_bottom = (counter_value == timer_pkg::BOTTOM_VAL);

  always_comb
  begin
    next_count = counter_value;
    next_down = count_down;
    unique case (family)
      timer_pkg::FAM_CTC, timer_pkg::FAM_FAST:
      begin
        next_down = 1'b0;
        next_count = at_top ? timer_pkg::BOTTOM_VAL : counter_value + 8'h01;
      end
      timer_pkg::FAM_PHASE:
      begin
        if (at_top)
          next_down = 1'b1;
        else if (at_bottom)
          next_down = 1'b0;
        next_count = next_down ? counter_value - 8'h01
                               : counter_value + 8'h01;
      end
      default:
      begin
        next_down = 1'b0;
        next_count = counter_value + 8'h01;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      counter_value <= timer_pkg::BOTTOM_VAL;
      count_down <= 1'b0;
    end
    else if (wr_count)
      counter_value <= wbyte;
    else if (timer_tick)
    begin
      counter_value <= next_count;
      count_down <= next_down;
    end
  end

  // ----------------------------------------------------------------
  // Compare buffers and capture register
  // ----------------------------------------------------------------
  logic buffer_load;
  always_comb
  begin
    unique case (family)
      timer_pkg::FAM_FAST: buffer_load = timer_tick && at_top;
      timer_pkg::FAM_PHASE: buffer_load = timer_tick && at_top;
      default: buffer_load = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_value_a <= timer_pkg::REG_RESET;
      compare_value_b <= timer_pkg::REG_RESET;
      active_cmp_a <= timer_pkg::REG_RESET;
      active_cmp_b <= timer_pkg::REG_RESET;
    end
    else
    begin
      if (wr_cmp_a)
        compare_value_a <= wbyte;
      if (wr_cmp_b)
        compare_value_b <= wbyte;
      if (buffer_load)
      begin
        active_cmp_a <= wr_cmp_a ? wbyte : compare_value_a;
        active_cmp_b <= wr_cmp_b ? wbyte : compare_value_b;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      capture_register <= timer_pkg::REG_RESET;
    else if (wr_capt)
      capture_register <= wbyte;
    else if (capture_event && top_sel != timer_pkg::TOP_CAPT)
      capture_register <= counter_value;
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic match_a;
  logic match_b;
  logic overflow;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  assign match_a = timer_tick && (counter_value == active_cmp_a);
  assign match_b = timer_tick && (counter_value == active_cmp_b);

  always_comb
  begin
    unique case (family)
      timer_pkg::FAM_FAST: overflow = timer_tick && at_top;
      timer_pkg::FAM_PHASE: overflow = timer_tick && at_bottom && count_down;
      default: overflow = timer_tick && (counter_value == timer_pkg::MAX_VAL);
    endcase
  end

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[timer_pkg::FLG_MATCH_A] = match_a;
    flag_set[timer_pkg::FLG_MATCH_B] = match_b;
    flag_set[timer_pkg::FLG_OVF] = overflow;
    flag_set[timer_pkg::FLG_CAPT] = (top_sel == timer_pkg::TOP_CAPT)
                                  ? (timer_tick && at_top)
                                  : capture_event;
    flag_clr = {4'h0, vector_ack};
    flag_clr[timer_pkg::FLG_CAPT] = vector_ack[3];
    flag_clr[3] = 1'b0;
    if (wr_flags)
      flag_clr = flag_clr | wbyte;
    flag_clr = flag_clr & timer_pkg::FLG_USED;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      timer1_flag_reg <= timer_pkg::REG_RESET;
    else
      timer1_flag_reg <= (timer1_flag_reg & ~flag_clr) | flag_set;
  end

  assign irq_request = {
    timer1_flag_reg[timer_pkg::FLG_CAPT] &
      interrupt_mask_reg[timer_pkg::FLG_CAPT],
    timer1_flag_reg[timer_pkg::FLG_MATCH_B] &
      interrupt_mask_reg[timer_pkg::FLG_MATCH_B],
    timer1_flag_reg[timer_pkg::FLG_MATCH_A] &
      interrupt_mask_reg[timer_pkg::FLG_MATCH_A],
    timer1_flag_reg[timer_pkg::FLG_OVF] &
      interrupt_mask_reg[timer_pkg::FLG_OVF]};

  // ----------------------------------------------------------------
  // Waveform generator
  // ----------------------------------------------------------------
  logic force_a;
  logic force_b;
  assign force_a = wr_ctrl_b && wbyte[timer_pkg::CB_FORCE_A];
  assign force_b = wr_ctrl_b && wbyte[timer_pkg::CB_FORCE_B];

  function automatic logic wave_next(input logic cur,
                                     input logic [1:0] om,
                                     input timer_pkg::family_t fam,
                                     input logic hit,
                                     input logic forced,
                                     input logic bottom_tick,
                                     input logic down);
    logic pwm;
    pwm = (fam == timer_pkg::FAM_FAST) || (fam == timer_pkg::FAM_PHASE);
    wave_next = cur;
    if (om == timer_pkg::COM_OFF)
      wave_next = 1'b0;
    else if (!pwm && (hit || forced))
    begin
      unique case (om)
        timer_pkg::COM_TOGGLE: wave_next = !cur;
        timer_pkg::COM_CLEAR: wave_next = 1'b0;
        default: wave_next = 1'b1;
      endcase
    end
    else if (pwm && fam == timer_pkg::FAM_FAST)
    begin
      if (hit)
        wave_next = (om == timer_pkg::COM_SET);
      else if (bottom_tick)
        wave_next = (om != timer_pkg::COM_SET);
    end
    else if (pwm && hit)
      wave_next = (om == timer_pkg::COM_SET) ? !down : down;
  endfunction : wave_next

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
    end
    else
    begin
      // Forced strobes reach the pins only in normal and CTC modes; flags ignore them
      compare_output_a <= wave_next(compare_output_a, out_mode_a, family,
                                    match_a, force_a, timer_tick && at_top,
                                    next_down);
      compare_output_b <= wave_next(compare_output_b, out_mode_b, family,
                                    match_b, force_b, timer_tick && at_top,
                                    next_down);
    end
  end

endmodule : timer_unit

// *** shared/timer_pkg.sv ***
// Constants for the 8-bit timer with compare, capture and flag logic
package timer_pkg;
  localparam int CNT_W = 8;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hFF;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_CAPT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  // Control register A fields
  localparam int CA_MODE_A_LSB = 6;
  localparam int CA_MODE_B_LSB = 4;
  localparam int CA_WGM_LO_LSB = 0;
  // Control register B fields
  localparam int CB_FORCE_A = 7;
  localparam int CB_FORCE_B = 6;
  localparam int CB_CAPT_EDGE = 5;
  localparam int CB_WGM_HI_LSB = 3;
  localparam int CB_CS_LSB = 0;
  localparam logic [7:0] CB_STORE_MASK = 8'h3F;
  // Flag bit positions
  localparam int FLG_CAPT = 5;
  localparam int FLG_MATCH_B = 2;
  localparam int FLG_MATCH_A = 1;
  localparam int FLG_OVF = 0;
  localparam logic [7:0] FLG_USED = 8'h27;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Clock source select codes
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESCALE_W = 10;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV256 = 7;
  localparam int TAP_DIV1024 = 9;
  // Waveform mode codes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC_MAX = 4'h1;
  localparam logic [3:0] WGM_CTC_A = 4'h2;
  localparam logic [3:0] WGM_FAST_MAX = 4'h3;
  localparam logic [3:0] WGM_PC_A = 4'h5;
  localparam logic [3:0] WGM_FAST_A = 4'h7;
  localparam logic [3:0] WGM_CTC_CAPT = 4'hC;
  localparam logic [3:0] WGM_FAST_CAPT = 4'hE;
  // Compare output actions
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // Mode families
  typedef enum logic [3:0] {
    FAM_NORMAL = 4'b0001,
    FAM_CTC = 4'b0010,
    FAM_FAST = 4'b0100,
    FAM_PHASE = 4'b1000
  } family_t;
  typedef enum logic [2:0] {
    TOP_MAX = 3'b001,
    TOP_CMP_A = 3'b010,
    TOP_CAPT = 3'b100
  } top_sel_t;
endpackage : timer_pkg

// *** tb/timer_unit_chk.sv ***
// Port assertions for the timer unit
`timescale 1ns/100ps
module timer_unit_chk (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [3:0] vector_ack, // Vector executed
  input wire logic [3:0] irq_request // Requests
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic acc;
  assign acc = psel && penable;
  property p_ready;
    pready;
  endproperty
  property p_err_phase;
    pslverr |-> acc;
  endproperty
  property p_err_unmapped;
    acc && paddr > 8'h1F |-> pslverr;
  endproperty
  property p_err_mapped;
    acc && paddr[1:0] == 2'h0 && paddr <= timer_pkg::OFS_FLAGS |-> !pslverr;
  endproperty
  property p_rd_hi;
    prdata[31:8] == 24'h000000;
  endproperty
  property p_rd_hold;
    !psel |=> $stable(prdata);
  endproperty
  property p_err_data;
    psel && !penable && !pwrite && paddr > 8'h1F |=> prdata == 32'h0;
  endproperty
  property p_mask_off;
    acc && pwrite && pstrb[0] && paddr == timer_pkg::OFS_MASK &&
      pwdata[7:0] == 8'h00 |=> irq_request == 4'h0 [*2];
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_phase: assert property (p_err_phase)
    else $error("stray err");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("no err");
  a_err_mapped: assert property (p_err_mapped)
    else $error("bad err");
  a_rd_hi: assert property (p_rd_hi) else $error("upper bits");
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  a_err_data: assert property (p_err_data) else $error("rdata set");
  a_mask_off: assert property (p_mask_off) else $error("unmasked");
  c_mask: cover property (acc && pwrite && paddr == timer_pkg::OFS_MASK);
  c_unmapped: cover property (acc && pslverr);
  c_ack: cover property (vector_ack != 4'h0);
endmodule : timer_unit_chk
bind timer_unit timer_unit_chk timer_unit_chk_i (
  .mclk(mclk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .vector_ack(vector_ack),
  .irq_request(irq_request)
);

// *** tb/timer_compare_and_flag_logic_bench.sv ***
// Self-checking bench for the timer unit
`timescale 1ns/100ps
module timer_compare_and_flag_logic_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, compare_output_a, compare_output_b, err;
  logic external_count_pin = 1'b0;
  logic capture_input_pin = 1'b0;
  logic [3:0] vector_ack = 4'h0;
  logic [3:0] irq_request;
  logic [31:0] rd, v;
  int mismatches = 0;
  int cmp_count = 0;
  int fm, c;
  always #20 mclk = ~mclk;
  timer_unit timer_unit_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .external_count_pin(external_count_pin),
    .capture_input_pin(capture_input_pin),
    .vector_ack(vector_ack),
    .irq_request(irq_request),
    .compare_output_a(compare_output_a),
    .compare_output_b(compare_output_b)
  );
  task end_of_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      mismatches++;
      end_of_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  initial
  begin
    v = $urandom(22);
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(timer_pkg::OFS_FLAGS, 32'h0);
    rdc(timer_pkg::OFS_COUNT, 32'h0);
    v = $urandom();
    wr(timer_pkg::OFS_CMP_B, v);
    rdc(timer_pkg::OFS_CMP_B, {24'h0, v[7:0]});
    wr(timer_pkg::OFS_COUNT, 32'h1F0);
    repeat (20) @(posedge mclk);
    rdc(timer_pkg::OFS_COUNT, 32'hF0);
    wr(timer_pkg::OFS_CMP_A, 32'hF4);
    wr(timer_pkg::OFS_CMP_B, 32'hF8);
    wr(timer_pkg::OFS_CTRL_B, 32'h1);
    repeat (8) @(posedge mclk);
    wr(timer_pkg::OFS_CTRL_B, 32'h0);
    apb(1'b0, timer_pkg::OFS_COUNT, 32'h0);
    c = int'(rd);
    fm = (c > 'hF4 ? 2 : 0) | (c > 'hF8 ? 4 : 0);
    rdc(timer_pkg::OFS_FLAGS, fm);
    wr(timer_pkg::OFS_CTRL_B, 32'h1);
    repeat (8) @(posedge mclk);
    wr(timer_pkg::OFS_CTRL_B, 32'h0);
    apb(1'b0, timer_pkg::OFS_COUNT, 32'h0);
    if (int'(rd) < 'hF0)
      fm = fm | 1;
    rdc(timer_pkg::OFS_FLAGS, fm);
    wr(timer_pkg::OFS_MASK, 32'h3);
    @(negedge mclk);
    chk({28'h0, irq_request}, fm & 3);
    @(posedge mclk);
    vector_ack <= 4'h1;
    @(posedge mclk);
    vector_ack <= 4'h0;
    fm = fm & 6;
    rdc(timer_pkg::OFS_FLAGS, fm);
    wr(timer_pkg::OFS_FLAGS, 32'h2);
    fm = fm & 5;
    rdc(timer_pkg::OFS_FLAGS, fm);
    wr(timer_pkg::OFS_FLAGS, 32'h0);
    rdc(timer_pkg::OFS_FLAGS, fm);
    @(negedge mclk);
    chk({28'h0, irq_request}, fm & 3);
    wr(timer_pkg::OFS_CTRL_A, 32'h50);
    wr(timer_pkg::OFS_CTRL_B, 32'hC0);
    rdc(timer_pkg::OFS_FLAGS, fm);
    @(negedge mclk);
    chk({30'h0, compare_output_a, compare_output_b}, 32'h3);
    wr(timer_pkg::OFS_CTRL_B, 32'h20);
    @(posedge mclk);
    capture_input_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(1'b0, timer_pkg::OFS_COUNT, 32'h0);
    v = rd;
    fm = fm | 'h20;
    rdc(timer_pkg::OFS_FLAGS, fm);
    rdc(timer_pkg::OFS_CAPT, v);
    wr(timer_pkg::OFS_MASK, 32'h24);
    @(negedge mclk);
    chk({28'h0, irq_request}, 32'hC);
    wr(timer_pkg::OFS_MASK, 32'h0);
    @(negedge mclk);
    chk({28'h0, irq_request}, 32'h0);
    for (int s = 6; s < 8; s++)
    begin
      apb(1'b0, timer_pkg::OFS_COUNT, 32'h0);
      c = int'(rd);
      wr(timer_pkg::OFS_CTRL_B, s);
      repeat (3)
      begin
        @(posedge mclk);
        external_count_pin <= ~external_count_pin;
        repeat (4) @(posedge mclk);
        external_count_pin <= ~external_count_pin;
        repeat (4) @(posedge mclk);
      end
      wr(timer_pkg::OFS_CTRL_B, 32'h0);
      rdc(timer_pkg::OFS_COUNT, (c + 3) & 'hFF);
    end
    rdc(8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    end_of_test;
  end
endmodule : timer_compare_and_flag_logic_bench
